// ### design/icc_pkg.sv
`default_nettype none
package icc_pkg;
  // ==========================================================
  // Register map
  localparam logic [6:0] CTRL_ADDR = 7'h01;
  localparam logic [15:0] CTRL_RESET = 16'h050E;
  // Reserved bits 14, 13 and 0 always read as zero
  localparam logic [15:0] CTRL_WMASK = 16'h9FFE;

  // ==========================================================
  // Field positions of the control register
  localparam int unsigned PATTERN_TEST_BIT = 15;
  localparam int unsigned AUTO_CLEAR_BIT = 12;
  localparam int unsigned ODD_PARITY_BIT = 11;
  localparam int unsigned WORD_PARITY_BIT = 10;
  localparam int unsigned FRAME_PARITY_BIT = 9;
  localparam int unsigned QUAD_BIT = 8;
  localparam int unsigned INVERT_A_BIT = 7;
  localparam int unsigned ALARM_2AWAY_BIT = 3;
  localparam int unsigned ALARM_1AWAY_BIT = 2;
  localparam int unsigned ALARM_COLLISION_BIT = 1;

  // ==========================================================
  // Channel pair field value that selects dual channel mode
  localparam logic [1:0] DUAL_PAIR_CODE = 2'h3;
  // Channels B and C stay active in dual mode
  localparam logic [3:0] DUAL_ACTIVE = 4'h6;
  localparam logic [3:0] QUAD_ACTIVE = 4'hF;

  // ==========================================================
  // Good-sample run that clears latched alarms
  localparam int unsigned GOOD_RUN = 64;
  localparam int unsigned GOOD_W = 7;
  localparam logic [GOOD_W-1:0] GOOD_RUN_CNT = 7'h40;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_CH = 4;
endpackage : icc_pkg
`default_nettype wire

// ### design/icc_input_check.sv
`timescale 1ns/10ps
`default_nettype none

module icc_input_check (
  input wire logic clk,
  input wire logic rst,
  // Decoded configuration port access
  input wire logic cfg_wr_en,
  input wire logic [6:0] cfg_addr,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  // Pair field of the channel pair configuration register
  input wire logic [1:0] channel_pair_field,
  // Input word bus
  input wire logic word_valid,
  input wire logic [15:0] data_in,
  input wire logic parity_input_pair,
  input wire logic frame_in,
  input wire logic [15:0] expected_pattern,
  // Alarm sources and software clear
  input wire logic alarm_clear,
  input wire logic fifo_collision,
  input wire logic fifo_1away,
  input wire logic fifo_2away,
  // Output enables from pin and serial bit
  input wire logic tx_enable_pin,
  input wire logic tx_enable_bit,
  // Per-channel sample data before the output stage
  input wire logic [15:0] ch_a_in,
  input wire logic [15:0] ch_b_in,
  input wire logic [15:0] ch_c_in,
  input wire logic [15:0] ch_d_in,
  output logic [15:0] ch_a_out,
  output logic [15:0] ch_b_out,
  output logic [15:0] ch_c_out,
  output logic [15:0] ch_d_out,
  output logic [3:0] channel_active,
  output logic dual_mode,
  output logic outputs_on,
  output logic pattern_alarm,
  output logic parity_alarm,
  output logic collision_alarm,
  output logic away1_alarm,
  output logic away2_alarm
);

  // ==========================================================
  // Control register
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;

  // Software writes, reserved bits forced low
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (cfg_wr_en && cfg_addr == icc_pkg::CTRL_ADDR) begin
      ctrl_nxt = cfg_wdata & icc_pkg::CTRL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= icc_pkg::CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Field views of the control word
  logic test_on;
  logic auto_clr;
  logic odd_sel;
  logic word_par_on;
  logic frame_par_on;
  logic quad_on;
  assign test_on = ctrl_r[icc_pkg::PATTERN_TEST_BIT];
  assign auto_clr = ctrl_r[icc_pkg::AUTO_CLEAR_BIT];
  assign odd_sel = ctrl_r[icc_pkg::ODD_PARITY_BIT];
  assign word_par_on = ctrl_r[icc_pkg::WORD_PARITY_BIT];
  assign frame_par_on = ctrl_r[icc_pkg::FRAME_PARITY_BIT];
  assign quad_on = ctrl_r[icc_pkg::QUAD_BIT];

  // ==========================================================
  // Checkers on each valid input word
  logic data_xor;
  logic word_bad;
  logic frame_bad;
  logic par_bad;
  logic pat_bad;
  logic sample_bad;
  // Even sense wants total ones even, odd sense wants it odd
  assign data_xor = ^data_in;
  assign word_bad = word_par_on &&
                    ((data_xor ^ parity_input_pair) != odd_sel);
  // Frame line carries the parity bit in this mode
  assign frame_bad = frame_par_on &&
                     ((data_xor ^ frame_in) != odd_sel);
  // Both checks may be on at once; either one failing counts.
  // Gaps carry junk parity, so word_valid qualifies every check.
  assign par_bad = word_valid && (word_bad || frame_bad);
  assign pat_bad = word_valid && test_on &&
                   (data_in != expected_pattern);
  assign sample_bad = par_bad || pat_bad;

  // ==========================================================
  // Good-sample run counter and latched alarms
  logic [icc_pkg::GOOD_W-1:0] good_cnt_r;
  logic [icc_pkg::GOOD_W-1:0] good_cnt_nxt;
  logic par_alarm_r;
  logic par_alarm_nxt;
  logic pat_alarm_r;
  logic pat_alarm_nxt;
  logic run_done;

  // Counter wraps after each full run, so a long clean run clears
  // again every 64 words; a bad word or auto clear off restarts it
  always_comb begin
    good_cnt_nxt = good_cnt_r;
    run_done = 1'b0;
    if (!auto_clr || sample_bad) begin
      good_cnt_nxt = '0;
    end else if (word_valid) begin
      if (good_cnt_r == icc_pkg::GOOD_RUN_CNT - 7'h01) begin
        run_done = 1'b1;
        good_cnt_nxt = '0;
      end else begin
        good_cnt_nxt = good_cnt_r + 7'h01;
      end
    end
    // New mismatch wins over any clear in the same cycle
    par_alarm_nxt = par_alarm_r;
    if (alarm_clear || run_done) begin
      par_alarm_nxt = 1'b0;
    end
    if (par_bad) begin
      par_alarm_nxt = 1'b1;
    end
    pat_alarm_nxt = pat_alarm_r;
    if (alarm_clear || run_done) begin
      pat_alarm_nxt = 1'b0;
    end
    if (pat_bad) begin
      pat_alarm_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      good_cnt_r <= '0;
      par_alarm_r <= 1'b0;
      pat_alarm_r <= 1'b0;
    end else begin
      good_cnt_r <= good_cnt_nxt;
      par_alarm_r <= par_alarm_nxt;
      pat_alarm_r <= pat_alarm_nxt;
    end
  end

  // ==========================================================
  // Buffer pointer alarms, gated by their enable bits
  logic coll_r;
  logic coll_nxt;
  logic a1_r;
  logic a1_nxt;
  logic a2_r;
  logic a2_nxt;

  // Raw alarms are levels; each flag follows its input one cycle late
  always_comb begin
    coll_nxt = fifo_collision &&
               ctrl_r[icc_pkg::ALARM_COLLISION_BIT];
    a1_nxt = fifo_1away && ctrl_r[icc_pkg::ALARM_1AWAY_BIT];
    a2_nxt = fifo_2away && ctrl_r[icc_pkg::ALARM_2AWAY_BIT];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      coll_r <= 1'b0;
      a1_r <= 1'b0;
      a2_r <= 1'b0;
    end else begin
      coll_r <= coll_nxt;
      a1_r <= a1_nxt;
      a2_r <= a2_nxt;
    end
  end

  // ==========================================================
  // Channel mode, enable and output data
  logic [3:0] act_nxt;
  logic [3:0] act_r;
  logic dual_nxt;
  logic dual_r;
  logic on_nxt;
  logic on_r;
  logic [15:0] ch_in [icc_pkg::NUM_CH];
  logic [15:0] ch_nxt [icc_pkg::NUM_CH];
  logic [15:0] ch_r [icc_pkg::NUM_CH];

  // Quad wins; dual only with quad clear and pair field 11.
  // Any other combination keeps all channels on as a safe fallback.
  always_comb begin
    dual_nxt = !quad_on &&
               channel_pair_field == icc_pkg::DUAL_PAIR_CODE;
    if (dual_nxt) begin
      act_nxt = icc_pkg::DUAL_ACTIVE;
    end else begin
      act_nxt = icc_pkg::QUAD_ACTIVE;
    end
    on_nxt = tx_enable_pin && tx_enable_bit && !test_on;
  end

  assign ch_in[0] = ch_a_in;
  assign ch_in[1] = ch_b_in;
  assign ch_in[2] = ch_c_in;
  assign ch_in[3] = ch_d_in;

  // Invert bits sit from bit 7 (A) down to bit 4 (D); idle channels zero
  for (genvar g = 0; g < icc_pkg::NUM_CH; g++) begin : g_ch
    always_comb begin
      if (!act_nxt[g]) begin
        ch_nxt[g] = '0;
      end else if (ctrl_r[icc_pkg::INVERT_A_BIT - g]) begin
        ch_nxt[g] = ~ch_in[g];
      end else begin
        ch_nxt[g] = ch_in[g];
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        ch_r[g] <= '0;
      end else begin
        ch_r[g] <= ch_nxt[g];
      end
    end
  end

  // Mode and enable registered so every output is a flip-flop
  always_ff @(posedge clk) begin
    if (rst) begin
      act_r <= '0;
      dual_r <= 1'b0;
      on_r <= 1'b0;
    end else begin
      act_r <= act_nxt;
      dual_r <= dual_nxt;
      on_r <= on_nxt;
    end
  end

  // ==========================================================
  // Read-back, registered so the port comes from a flip-flop
  logic [15:0] rd_r;
  logic [15:0] rd_nxt;

  always_comb begin
    rd_nxt = '0;
    if (cfg_addr == icc_pkg::CTRL_ADDR) begin
      rd_nxt = ctrl_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign cfg_rdata = rd_r;
  assign ch_a_out = ch_r[0];
  assign ch_b_out = ch_r[1];
  assign ch_c_out = ch_r[2];
  assign ch_d_out = ch_r[3];
  assign channel_active = act_r;
  assign dual_mode = dual_r;
  assign outputs_on = on_r;
  assign pattern_alarm = pat_alarm_r;
  assign parity_alarm = par_alarm_r;
  assign collision_alarm = coll_r;
  assign away1_alarm = a1_r;
  assign away2_alarm = a2_r;

endmodule : icc_input_check

`default_nettype wire

// ### tb/icc_checker.sv
`timescale 1ns/10ps
`default_nettype none
module icc_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_wr_en,
  input wire logic [6:0] cfg_addr,
  input wire logic [15:0] cfg_wdata,
  input wire logic [1:0] channel_pair_field,
  input wire logic word_valid,
  input wire logic [15:0] data_in,
  input wire logic parity_input_pair,
  input wire logic frame_in,
  input wire logic [15:0] expected_pattern,
  input wire logic alarm_clear,
  input wire logic fifo_collision,
  input wire logic tx_enable_pin,
  input wire logic tx_enable_bit,
  input wire logic [15:0] ch_a_in,
  input wire logic [15:0] ch_a_out,
  input wire logic [3:0] channel_active,
  input wire logic dual_mode,
  input wire logic outputs_on,
  input wire logic pattern_alarm,
  input wire logic parity_alarm,
  input wire logic collision_alarm
);
  logic [15:0] ctl_r, ctl_nxt;
  logic bad_par;
  // ======
  // Shadow control word, so rules need no internal probes
  always_comb begin
    ctl_nxt = ctl_r;
    if (cfg_wr_en && cfg_addr == 7'h01)
      ctl_nxt = cfg_wdata & 16'h9FFE;
    if (rst)
      ctl_nxt = 16'h050E;
  end
  always_ff @(posedge clk) begin
    ctl_r <= ctl_nxt;
  end
  // Word failing whichever parity check is on
  assign bad_par = word_valid &&
    ((ctl_r[10] && ^{data_in, parity_input_pair} != ctl_r[11]) ||
    (ctl_r[9] && ^{data_in, frame_in} != ctl_r[11]));
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ======
  // Properties
  chk_pattern_flag:
    assert property (word_valid && ctl_r[15] && data_in != expected_pattern
      |=> pattern_alarm) else $error("pattern miss not flagged");
  chk_output_gate:
    assert property (1'b1 |=> outputs_on ==
      $past(!ctl_r[15] && tx_enable_pin && tx_enable_bit))
      else $error("output enable wrong");
  chk_parity_flag:
    assert property (bad_par |=> parity_alarm)
      else $error("parity miss not flagged");
  chk_parity_hold:
    assert property (parity_alarm && !alarm_clear && !ctl_r[12]
      |=> parity_alarm) else $error("parity flag dropped");
  chk_quad_all:
    assert property (ctl_r[8] |=> channel_active == 4'hF)
      else $error("quad channels wrong");
  chk_dual_pair:
    assert property (!ctl_r[8] && channel_pair_field == 2'h3
      |=> channel_active == 4'h6 && dual_mode) else $error("dual wrong");
  chk_invert_a:
    assert property (ctl_r[8] |=> ch_a_out ==
      ($past(ch_a_in) ^ {16{$past(ctl_r[7])}})) else $error("ch a wrong");
  chk_collision_gate:
    assert property (1'b1 |=> collision_alarm ==
      $past(fifo_collision && ctl_r[1])) else $error("collision wrong");
  cover property (ctl_r[12] && $fell(parity_alarm));
  cover property (dual_mode);
  cover property (pattern_alarm && !outputs_on);
endmodule : icc_checker
`default_nettype wire

// ### tb/icc_source.sv
`timescale 1ns/10ps
`default_nettype none
module icc_source (
  input wire logic clk,
  input wire logic odd,
  input wire logic slow,
  input wire logic [1:0] bad,
  output logic word_valid,
  output logic [15:0] data_in,
  output logic parity_input_pair,
  output logic frame_in
);
  logic [15:0] cnt_r = 16'h0001;
  initial {word_valid, data_in, parity_input_pair, frame_in} = 19'h0;
  // ======
  // Word each cycle; slow mode leaves gaps carrying junk parity
  always @(posedge clk) begin
    #2;
    cnt_r = cnt_r * 16'h0003 + 16'h0007;
    word_valid = !(slow && cnt_r[0]);
    data_in = cnt_r;
    parity_input_pair = ^cnt_r ^ odd ^ bad[0] ^ !word_valid;
    frame_in = ^cnt_r ^ odd ^ bad[1] ^ !word_valid;
  end
endmodule : icc_source
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk, rst, cfg_wr_en, word_valid, parity_input_pair, frame_in;
  logic alarm_clear, fifo_collision, fifo_1away, fifo_2away, perr;
  logic tx_enable_pin, tx_enable_bit, dual_mode, outputs_on, odd, slow;
  logic pattern_alarm, parity_alarm, collision_alarm, away1_alarm;
  logic away2_alarm;
  logic [1:0] channel_pair_field, bad;
  logic [3:0] channel_active;
  logic [6:0] cfg_addr;
  logic [15:0] cfg_wdata, cfg_rdata, data_in, expected_pattern;
  logic [15:0] ch_a_in, ch_b_in, ch_c_in, ch_d_in;
  logic [15:0] ch_a_out, ch_b_out, ch_c_out, ch_d_out;
  int error_cnt = 0;
  int cmp_count = 0;
  icc_input_check uut (.*);
  icc_source src (.*);
  // Pattern expected by the checker, broken on demand
  assign expected_pattern = data_in ^ {15'h0, perr};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #50000;
    error_cnt++;
    complete_run();
  end
  task automatic complete_run();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Write strobe is one cycle; effects visible on return
  task automatic wr(logic [6:0] a, logic [15:0] d);
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    cyc(1);
    cfg_wr_en = 1'b0;
    cfg_addr = 7'h01;
    cyc(1);
  endtask : wr
  task automatic inject(logic [1:0] b, int n);
    bad = b;
    cyc(n);
    bad = 2'h0;
  endtask : inject
  task automatic t_reset();
    chk("ctrl", 16'h050E, cfg_rdata);
    chk("active", 16'h000F, 16'(channel_active));
    chk("coll", 16'h0001, 16'(collision_alarm));
    tx_enable_bit = 1'b0;
    {fifo_1away, fifo_2away} = 2'h3;
    cyc(2);
    chk("outs", 16'h0000, 16'(outputs_on));
    chk("away1", 16'h0001, 16'(away1_alarm));
    chk("away2", 16'h0001, 16'(away2_alarm));
    tx_enable_bit = 1'b1;
  endtask : t_reset
  task automatic t_regs();
    wr(7'h01, 16'hFFFF);
    chk("ctrl", 16'h9FFE, cfg_rdata);
    chk("ch_d", ~ch_d_in, ch_d_out);
    chk("ch_a", ~ch_a_in, ch_a_out);
    wr(7'h05, 16'h0000);
    chk("ctrl", 16'h9FFE, cfg_rdata);
    cfg_addr = 7'h05;
    cyc(1);
    chk("unmapped", 16'h0000, cfg_rdata);
    cfg_addr = 7'h01;
  endtask : t_regs
  task automatic t_chan();
    wr(7'h01, 16'h0560);
    chk("ch_b", ~ch_b_in, ch_b_out);
    chk("ch_c", ~ch_c_in, ch_c_out);
    chk("coll", 16'h0000, 16'(collision_alarm));
    chk("away1", 16'h0000, 16'(away1_alarm));
    chk("away2", 16'h0000, 16'(away2_alarm));
    channel_pair_field = 2'h3;
    wr(7'h01, 16'h0400);
    chk("active", 16'h0006, 16'(channel_active));
    chk("ch_a", 16'h0000, ch_a_out);
    chk("dual", 16'h0001, 16'(dual_mode));
    channel_pair_field = 2'h2;
    cyc(2);
    chk("dual", 16'h0000, 16'(dual_mode));
  endtask : t_chan
  // Each sense and source; a flip on the unused line must pass
  task automatic t_parity();
    slow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      odd = i[0];
      wr(7'h01, (i[1] ? 16'h0300 : 16'h0500) | {4'h0, i[0], 11'h0});
      alarm_clear = 1'b1;
      cyc(1);
      alarm_clear = 1'b0;
      inject(i[1] ? 2'h1 : 2'h2, 2);
      cyc(2);
      chk("parity", 16'h0000, 16'(parity_alarm));
      inject(i[1] ? 2'h2 : 2'h1, 2);
      cyc(2);
      chk("parity", 16'h0001, 16'(parity_alarm));
    end
    slow = 1'b0;
  endtask : t_parity
  task automatic t_auto();
    wr(7'h01, 16'h1D00);
    inject(2'h1, 1);
    cyc(63);
    chk("parity", 16'h0001, 16'(parity_alarm));
    cyc(1);
    chk("parity", 16'h0000, 16'(parity_alarm));
  endtask : t_auto
  task automatic t_pattern();
    wr(7'h01, 16'h8D00);
    chk("outs", 16'h0000, 16'(outputs_on));
    chk("pattern", 16'h0000, 16'(pattern_alarm));
    perr = 1'b1;
    cyc(1);
    perr = 1'b0;
    cyc(1);
    chk("pattern", 16'h0001, 16'(pattern_alarm));
  endtask : t_pattern
  initial begin
    {rst, tx_enable_pin, tx_enable_bit, fifo_collision} = 4'hF;
    {cfg_wr_en, alarm_clear, fifo_1away, fifo_2away, perr} = 5'h0;
    {odd, slow, bad, channel_pair_field} = 6'h0;
    cfg_addr = 7'h01;
    cfg_wdata = 16'h0000;
    {ch_a_in, ch_b_in} = 32'h1234_5678;
    {ch_c_in, ch_d_in} = 32'h9ABC_DEF0;
    cyc(20);
    rst = 1'b0;
    cyc(3);
    t_reset();
    t_regs();
    t_chan();
    t_parity();
    t_auto();
    t_pattern();
    complete_run();
  end
endmodule : testbench
bind icc_input_check icc_checker chk_i (.*);
`default_nettype wire
